// *** ddr2_ctrl_end.sv ***
// controller end: issues commands keeping ddr2 spacing
`default_nettype none
module ddr2_ctrl_end
	import ddr2_timing_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              req_valid_i,
	input  wire cmd_t              req_cmd_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	output logic                   req_ready_o,
	input  wire logic              odt_req_i,
	input  wire logic              freq_change_req_i,
	output logic                   freq_change_ok_o,
	input  wire logic              rewrite_done_i,
	output logic                   data_suspect_o,
	ddr2_link_if.ctrl              link
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_OPEN,
		ST_PD_PRE,
		ST_PD_ACT
	} state_t;

	// ==========================================================
	// state
	state_t            state_q, state_d;
	cmd_t              cmd_q, cmd_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic              cke_q, cke_d;
	logic              odt_q, odt_d;
	logic              slow_q, slow_d;
	tcnt_t             rd2pre_q, rd2pre_d;
	tcnt_t             ras_q, ras_d;
	tcnt_t             rp_q, rp_d;
	tcnt_t             wr2rd_q, wr2rd_d;
	tcnt_t             dal_q, dal_d;
	tcnt_t             hold_q, hold_d;
	tcnt_t             pdx_rd_q, pdx_rd_d;
	tcnt_t             pdx_any_q, pdx_any_d;
	tcnt_t             wstart_q, wstart_d;
	tcnt_t             wburst_q, wburst_d;
	rcnt_t             refi_q, refi_d;
	logic              suspect_q, suspect_d;

	logic legal;
	logic fire;

	function automatic tcnt_t dec(input tcnt_t v);
		dec = (v != CNT_ZERO) ? v - 5'h01 : CNT_ZERO;
	endfunction

	// ==========================================================
	// legality of the requested command
	always_comb begin
		legal = 1'b0;
		unique case (req_cmd_i)
			CMD_NOP: begin
				legal = 1'b1;
			end
			CMD_ACT: begin
				legal = (state_q == ST_IDLE) && pdx_any_q == CNT_ZERO
				        && dal_q == CNT_ZERO && rp_q == CNT_ZERO;
			end
			CMD_RD: begin
				legal = (state_q == ST_OPEN) && wr2rd_q == CNT_ZERO
				        && pdx_rd_q == CNT_ZERO && pdx_any_q == CNT_ZERO;
			end
			CMD_WR, CMD_WRA: begin
				legal = (state_q == ST_OPEN) && pdx_any_q == CNT_ZERO;
			end
			CMD_PRE: begin
				legal = (state_q == ST_OPEN) && rd2pre_q == CNT_ZERO
				        && ras_q == CNT_ZERO && dal_q == CNT_ZERO
				        && wr2rd_q == CNT_ZERO;
			end
			CMD_REF, CMD_MRS: begin
				legal = (state_q == ST_IDLE) && rp_q == CNT_ZERO
				        && pdx_any_q == CNT_ZERO && dal_q == CNT_ZERO;
			end
			CMD_PDE: begin
				legal = (state_q == ST_IDLE || state_q == ST_OPEN)
				        && hold_q == CNT_ZERO && wburst_q == CNT_ZERO
				        && wstart_q == CNT_ZERO;
			end
			CMD_PDX: begin
				legal = (state_q == ST_PD_PRE || state_q == ST_PD_ACT)
				        && hold_q == CNT_ZERO && !freq_change_req_i;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	assign fire        = req_valid_i & legal;
	assign req_ready_o = legal;

	// ==========================================================
	// next state
	always_comb begin
		state_d   = state_q;
		cmd_d     = CMD_NOP;
		addr_d    = addr_q;
		cke_d     = cke_q;
		odt_d     = odt_req_i;
		slow_d    = slow_q;
		rd2pre_d  = dec(rd2pre_q);
		ras_d     = dec(ras_q);
		rp_d      = dec(rp_q);
		wr2rd_d   = dec(wr2rd_q);
		dal_d     = dec(dal_q);
		hold_d    = dec(hold_q);
		pdx_rd_d  = dec(pdx_rd_q);
		pdx_any_d = dec(pdx_any_q);
		wstart_d  = dec(wstart_q);
		wburst_d  = dec(wburst_q);
		// strobe burst opens when write latency expires
		if (wstart_q == 5'h01) begin
			wburst_d = LD_WBURST;
		end
		refi_d    = (refi_q != RCNT_ZERO) ? refi_q - 10'h001 : RCNT_ZERO;
		// set wins over rewrite clear
		suspect_d = (refi_q == RCNT_ZERO) | (suspect_q & ~rewrite_done_i);
		if (fire) begin
			unique case (req_cmd_i)
				CMD_NOP: begin
				end
				CMD_ACT: begin
					cmd_d   = CMD_ACT;
					addr_d  = req_addr_i;
					ras_d   = LD_RAS;
					state_d = ST_OPEN;
				end
				CMD_RD: begin
					cmd_d    = CMD_RD;
					addr_d   = req_addr_i;
					rd2pre_d = LD_RD2PRE;
				end
				CMD_WR: begin
					cmd_d    = CMD_WR;
					addr_d   = req_addr_i;
					wr2rd_d  = LD_WR2RD;
					wstart_d = LD_WSTART;
				end
				CMD_WRA: begin
					cmd_d    = CMD_WRA;
					addr_d   = req_addr_i;
					dal_d    = LD_DAL;
					wstart_d = LD_WSTART;
					state_d  = ST_IDLE;
				end
				CMD_PRE: begin
					cmd_d   = CMD_PRE;
					addr_d  = req_addr_i;
					rp_d    = LD_RP;
					state_d = ST_IDLE;
				end
				CMD_REF: begin
					cmd_d  = CMD_REF;
					refi_d = LD_REFI;
					rp_d   = LD_RP;
				end
				CMD_MRS: begin
					cmd_d  = CMD_MRS;
					addr_d = req_addr_i;
					slow_d = req_addr_i[MODE_SLOW_EXIT_POS];
				end
				CMD_PDE: begin
					cke_d   = 1'b0;
					hold_d  = LD_CKE;
					state_d = (state_q == ST_OPEN) ? ST_PD_ACT : ST_PD_PRE;
				end
				// slow or fast exit to read
				CMD_PDX: begin
					cke_d     = 1'b1;
					hold_d    = LD_CKE;
					pdx_any_d = LD_XP;
					if (state_q == ST_PD_ACT) begin
						pdx_rd_d = slow_q ? LD_XARDS : LD_XARD;
						state_d  = ST_OPEN;
					end else begin
						state_d  = ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q   <= ST_IDLE;
			cmd_q     <= CMD_NOP;
			addr_q    <= '0;
			cke_q     <= 1'b1;
			odt_q     <= 1'b0;
			slow_q    <= 1'b0;
			rd2pre_q  <= CNT_ZERO;
			ras_q     <= CNT_ZERO;
			rp_q      <= CNT_ZERO;
			wr2rd_q   <= CNT_ZERO;
			dal_q     <= CNT_ZERO;
			hold_q    <= LD_CKE;
			pdx_rd_q  <= CNT_ZERO;
			pdx_any_q <= CNT_ZERO;
			wstart_q  <= CNT_ZERO;
			wburst_q  <= CNT_ZERO;
			refi_q    <= LD_REFI;
			suspect_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cmd_q     <= cmd_d;
			addr_q    <= addr_d;
			cke_q     <= cke_d;
			odt_q     <= odt_d;
			slow_q    <= slow_d;
			rd2pre_q  <= rd2pre_d;
			ras_q     <= ras_d;
			rp_q      <= rp_d;
			wr2rd_q   <= wr2rd_d;
			dal_q     <= dal_d;
			hold_q    <= hold_d;
			pdx_rd_q  <= pdx_rd_d;
			pdx_any_q <= pdx_any_d;
			wstart_q  <= wstart_d;
			wburst_q  <= wburst_d;
			refi_q    <= refi_d;
			suspect_q <= suspect_d;
		end
	end

	// ==========================================================
	// outputs
	// clock change only in precharge power-down
	assign freq_change_ok_o = (state_q == ST_PD_PRE) && hold_q == CNT_ZERO;
	assign data_suspect_o   = suspect_q;
	assign link.cke         = cke_q;
	assign link.cmd         = cmd_q;
	assign link.addr        = addr_q;
	assign link.odt         = odt_q;
	// strobe stops with the burst; a longer tail would only slow turnaround
	assign link.dqs_drive   = (wburst_q != CNT_ZERO);

endmodule
`default_nettype wire

// *** ddr2_dram_end.sv ***
// dram end: mode capture, termination timing, spacing checks
`default_nettype none
module ddr2_dram_end
	import ddr2_timing_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   reset_n_i,
	ddr2_link_if.dram   link,
	output logic        term_on_o,
	output logic        slow_exit_o,
	output cmd_t        cmd_o,
	output logic        power_down_o,
	output logic        violation_o,
	output logic        strobe_busy_o
);

	// ==========================================================
	// state
	logic [1:0] odt_pipe_q, odt_pipe_d;
	logic       term_q, term_d;
	logic       term_half_q;
	logic       slow_q, slow_d;
	cmd_t       cmd_q, cmd_d;
	logic       cke_q, cke_d;
	tcnt_t      hold_q, hold_d;
	tcnt_t      wr2rd_q, wr2rd_d;
	tcnt_t      pdx_q, pdx_d;
	logic       viol_q, viol_d;
	logic       strobe_q, strobe_d;

	always_comb begin
		odt_pipe_d = {odt_pipe_q[0], link.odt};
		term_d     = odt_pipe_q[1];
		slow_d     = slow_q;
		cmd_d      = link.cke ? link.cmd : CMD_NOP;
		cke_d      = link.cke;
		hold_d     = (hold_q != CNT_ZERO) ? hold_q - 5'h01 : CNT_ZERO;
		wr2rd_d    = (wr2rd_q != CNT_ZERO) ? wr2rd_q - 5'h01 : CNT_ZERO;
		pdx_d      = (pdx_q != CNT_ZERO) ? pdx_q - 5'h01 : CNT_ZERO;
		viol_d     = 1'b0;
		// strobe tail only shown as busy, never flagged
		strobe_d   = link.dqs_drive;
		if (link.cke != cke_q) begin
			hold_d = LD_CKE;
			if (hold_q != CNT_ZERO) begin
				viol_d = 1'b1;
			end
			if (link.cke) begin
				pdx_d = slow_q ? LD_XARDS : LD_XARD;
			end
		end
		if (link.cke) begin
			unique case (link.cmd)
				CMD_MRS: begin
					slow_d = link.addr[MODE_SLOW_EXIT_POS];
				end
				CMD_WR, CMD_WRA: begin
					wr2rd_d = LD_WR2RD;
				end
				CMD_RD: begin
					if (wr2rd_q != CNT_ZERO || pdx_q != CNT_ZERO) begin
						viol_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			odt_pipe_q <= 2'h0;
			term_q     <= 1'b0;
			slow_q     <= 1'b0;
			cmd_q      <= CMD_NOP;
			cke_q      <= 1'b0;
			hold_q     <= CNT_ZERO;
			wr2rd_q    <= CNT_ZERO;
			pdx_q      <= CNT_ZERO;
			viol_q     <= 1'b0;
			strobe_q   <= 1'b0;
		end else begin
			odt_pipe_q <= odt_pipe_d;
			term_q     <= term_d;
			slow_q     <= slow_d;
			cmd_q      <= cmd_d;
			cke_q      <= cke_d;
			hold_q     <= hold_d;
			wr2rd_q    <= wr2rd_d;
			pdx_q      <= pdx_d;
			viol_q     <= viol_d;
			strobe_q   <= strobe_d;
		end
	end

	// ==========================================================
	// half-period stretch of termination release
	// off half a clock later
	always_ff @(negedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			term_half_q <= 1'b0;
		end else begin
			term_half_q <= term_q;
		end
	end

	assign term_on_o     = term_q | term_half_q;
	assign slow_exit_o   = slow_q;
	assign cmd_o         = cmd_q;
	assign power_down_o  = ~cke_q;
	assign violation_o   = viol_q;
	assign strobe_busy_o = strobe_q;

endmodule
`default_nettype wire

// *** ddr2_link_chk.sv ***
// assertions watching the ddr2 command link between the two ends
`default_nettype none
module ddr2_link_chk
	import ddr2_timing_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              reset_n_i,
	input wire logic              cke,
	input wire cmd_t              cmd,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              odt,
	input wire logic              dqs_drive
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// ==========
	// exit mode as last written on the link
	logic slow_q;
	logic slow_d;

	always_comb begin
		slow_d = slow_q;
		if (cmd == CMD_MRS) slow_d = addr[MODE_SLOW_EXIT_POS];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) slow_q <= 1'b0;
		else slow_q <= slow_d;
	end

	// ==========
	// sequences
	sequence s_exit;
		$rose(cke);
	endsequence

	sequence s_burst;
		dqs_drive [*2];
	endsequence

	// ==========
	// properties
	property p_rd_pre;
		cmd == CMD_RD |=> cmd != CMD_PRE;
	endproperty
	property p_cke_hold;
		$changed(cke) |=> $stable(cke) [*2];
	endproperty
	property p_wr_rd;
		cmd == CMD_WR |=> (cmd != CMD_RD) [*5];
	endproperty
	property p_strobe;
		cmd inside {CMD_WR, CMD_WRA} |=> ##1 s_burst;
	endproperty
	property p_exit_any;
		s_exit |=> cmd == CMD_NOP;
	endproperty
	property p_slow_exit;
		$rose(cke) && slow_q |=> (cmd != CMD_RD) [*7];
	endproperty
	property p_act_pre;
		cmd == CMD_ACT |=> (cmd != CMD_PRE) [*4];
	endproperty
	property p_pre_act;
		cmd == CMD_PRE |=> cmd != CMD_ACT;
	endproperty
	property p_wra_act;
		cmd == CMD_WRA |=> (cmd != CMD_ACT) [*8];
	endproperty
	// power-down keeps the link quiet; odt alone may move
	property p_pd_quiet;
		!cke |-> cmd == CMD_NOP && !dqs_drive;
	endproperty

	a_rd_pre: assert property (p_rd_pre) else $error("precharge too soon after read");
	a_cke_hold: assert property (p_cke_hold) else $error("clock enable changed too soon");
	a_wr_rd: assert property (p_wr_rd) else $error("read too soon after write");
	a_strobe: assert property (p_strobe) else $error("write strobe window wrong");
	a_exit_any: assert property (p_exit_any) else $error("command too soon after exit");
	a_slow_exit: assert property (p_slow_exit) else $error("read too soon after slow exit");
	a_act_pre: assert property (p_act_pre) else $error("row closed too soon");
	a_pre_act: assert property (p_pre_act) else $error("activate too soon after precharge");
	a_wra_act: assert property (p_wra_act) else $error("activate too soon after write autoprecharge");
	a_pd_quiet: assert property (p_pd_quiet) else $error("traffic during power-down");
endmodule
`default_nettype wire

// *** ddr2_link_if.sv ***
// command link between controller end and dram end
`default_nettype none
interface ddr2_link_if;
	import ddr2_timing_pkg::*;

	logic              cke;
	cmd_t              cmd;
	logic [ADDR_W-1:0] addr;
	logic              odt;
	logic              dqs_drive;

	modport ctrl (
		output cke,
		output cmd,
		output addr,
		output odt,
		output dqs_drive
	);

	modport dram (
		input cke,
		input cmd,
		input addr,
		input odt,
		input dqs_drive
	);
endinterface
`default_nettype wire

// *** ddr2_timing_pkg.sv ***
// shared constants and types for the ddr2 command timing ends
// Operation
// - precharge after read waits latency plus half burst
// - cke held three sampled edges per change
// - two clocks from write burst end to read
// - missed refresh marks data suspect until rewritten
// - mode bit picks fast or slow exit
// - exit to read two, or eight/seven minus latency
// - termination on two edges after first high
// - termination off half clock after second edge
// - clock change only in precharge power-down
// - nanosecond limits rounded up to whole cycles; refresh interval rounded down
// - autoprecharge recovery is recovery plus precharge cycles
// - activate two or three edges after exit
// - long write postamble tolerated, costs turnaround only
`default_nettype none
package ddr2_timing_pkg;

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_ACT,
		CMD_RD,
		CMD_WR,
		CMD_WRA,
		CMD_PRE,
		CMD_REF,
		CMD_MRS,
		CMD_PDE,
		CMD_PDX
	} cmd_t;

	typedef logic [4:0] tcnt_t;
	typedef logic [9:0] rcnt_t;

	// ==========================================================
	// link and mode constants
	localparam int ADDR_W            = 14;
	localparam int MODE_SLOW_EXIT_POS = 12;
	localparam int FASTEST_GRADE     = 0;

	// ==========================================================
	// latencies in clocks
	localparam int ADDITIVE_LATENCY = 0;
	localparam int CAS_LATENCY      = 3;
	localparam int BURST_LENGTH     = 4;
	localparam int WRITE_RECOVERY   = 3;
	localparam int WRITE_LATENCY    = ADDITIVE_LATENCY + CAS_LATENCY - 1;
	localparam int CKE_HOLD_EDGES   = 3;
	localparam int WRITE_TO_READ_TURNAROUND  = 2;
	localparam int FAST_ACTIVE_PD_EXIT_DELAY = 2;
	localparam int SLOW_ACTIVE_PD_EXIT_DELAY = (FASTEST_GRADE != 0) ? 7 - ADDITIVE_LATENCY
	                                                                : 8 - ADDITIVE_LATENCY;
	localparam int POWER_DOWN_EXIT_DELAY     = (FASTEST_GRADE != 0) ? 3 : 2;
	localparam int TERMINATION_ON_LATENCY    = 2;

	// ==========================================================
	// nanosecond limits, in ps, and their cycle counts, rounded up except the refresh interval
	localparam int CLK_PERIOD_PS = 10000;
	localparam int T_RP_PS       = 15000;
	localparam int T_RAS_PS      = 45000;
	localparam int T_RTP_PS      = 7500;
	localparam int T_REFI_PS     = 7800000;
	localparam int N_RP  = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_RAS = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_RTP = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// longest interval rounds down
	localparam int N_REFI = T_REFI_PS / CLK_PERIOD_PS;

	// ==========================================================
	// counter reload values (wait of n clocks loads n-1; strobe start and burst load n)
	localparam int RD2PRE_RAW = ADDITIVE_LATENCY + BURST_LENGTH / 2;
	localparam tcnt_t LD_RD2PRE = tcnt_t'(((RD2PRE_RAW > N_RTP) ? RD2PRE_RAW : N_RTP) - 1);
	localparam tcnt_t LD_RAS    = tcnt_t'(N_RAS - 1);
	localparam tcnt_t LD_RP     = tcnt_t'(N_RP - 1);
	localparam tcnt_t LD_WR2RD  = tcnt_t'(WRITE_LATENCY + BURST_LENGTH / 2
	                                      + WRITE_TO_READ_TURNAROUND - 1);
	localparam tcnt_t LD_DAL    = tcnt_t'(WRITE_LATENCY + BURST_LENGTH / 2
	                                      + WRITE_RECOVERY + N_RP - 1);
	localparam tcnt_t LD_CKE    = tcnt_t'(CKE_HOLD_EDGES - 1);
	localparam tcnt_t LD_XARD   = tcnt_t'(FAST_ACTIVE_PD_EXIT_DELAY - 1);
	localparam tcnt_t LD_XARDS  = tcnt_t'(SLOW_ACTIVE_PD_EXIT_DELAY - 1);
	localparam tcnt_t LD_XP     = tcnt_t'(POWER_DOWN_EXIT_DELAY - 1);
	localparam tcnt_t LD_WSTART = tcnt_t'(WRITE_LATENCY);
	localparam tcnt_t LD_WBURST = tcnt_t'(BURST_LENGTH / 2);
	localparam rcnt_t LD_REFI   = rcnt_t'(N_REFI - 1);
	localparam tcnt_t CNT_ZERO  = 5'h00;
	localparam rcnt_t RCNT_ZERO = 10'h000;

endpackage
`default_nettype wire

// *** testbench.sv ***
// self-checking bench joining the controller end and the dram end
`default_nettype none
module testbench
	import ddr2_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========
	// stimulus and observed signals
	logic              clk_i             = 1'b0;
	logic              reset_n_i         = 1'b0;
	logic              req_valid_i       = 1'b0;
	cmd_t              req_cmd_i         = CMD_NOP;
	logic [ADDR_W-1:0] req_addr_i        = 14'h0000;
	logic              odt_req_i         = 1'b0;
	logic              freq_change_req_i = 1'b0;
	logic              rewrite_done_i    = 1'b0;
	logic              req_ready_o;
	logic              freq_change_ok_o;
	logic              data_suspect_o;
	logic              term_on_o;
	logic              slow_exit_o;
	logic              power_down_o;
	logic              violation_o;
	logic              strobe_busy_o;
	cmd_t              cmd_o;
	int                num_errors        = 0;
	int                n_checks          = 0;
	int                cyc               = 0;
	int                last              = 0;
	int                gap               = 0;
	// spacings rounded up from picoseconds, worked out here on purpose
	int                n_ras             = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	int                n_rp              = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	always #5 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
	end

	// ==========
	// design ends and link checker
	ddr2_link_if ddr2_link_if_inst ();

	ddr2_ctrl_end ddr2_ctrl_end_inst (
		.clk_i             (clk_i),
		.reset_n_i         (reset_n_i),
		.req_valid_i       (req_valid_i),
		.req_cmd_i         (req_cmd_i),
		.req_addr_i        (req_addr_i),
		.req_ready_o       (req_ready_o),
		.odt_req_i         (odt_req_i),
		.freq_change_req_i (freq_change_req_i),
		.freq_change_ok_o  (freq_change_ok_o),
		.rewrite_done_i    (rewrite_done_i),
		.data_suspect_o    (data_suspect_o),
		.link              (ddr2_link_if_inst)
	);

	ddr2_dram_end ddr2_dram_end_inst (
		.clk_i         (clk_i),
		.reset_n_i     (reset_n_i),
		.link          (ddr2_link_if_inst),
		.term_on_o     (term_on_o),
		.slow_exit_o   (slow_exit_o),
		.cmd_o         (cmd_o),
		.power_down_o  (power_down_o),
		.violation_o   (violation_o),
		.strobe_busy_o (strobe_busy_o)
	);

	ddr2_link_chk ddr2_link_chk_inst (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.cke       (ddr2_link_if_inst.cke),
		.cmd       (ddr2_link_if_inst.cmd),
		.addr      (ddr2_link_if_inst.addr),
		.odt       (ddr2_link_if_inst.odt),
		.dqs_drive (ddr2_link_if_inst.dqs_drive)
	);

	// ==========
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// request held until taken; gap is edges since the previous take
	task automatic send(input cmd_t c, input logic [ADDR_W-1:0] a);
		int i;
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_cmd_i   <= c;
		req_addr_i  <= a;
		for (i = 0; i < 100; i++) begin
			@(negedge clk_i);
			if (req_ready_o === 1'b1) break;
		end
		if (i == 100) begin
			num_errors++;
			results();
		end
		gap  = cyc + 1 - last;
		last = cyc + 1;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
	endtask

	// samples straddle the edge where termination switches and the half period after it
	task automatic odt_step(input logic v);
		@(posedge clk_i);
		odt_req_i <= v;
		repeat (3) @(posedge clk_i);
		#7 chk(term_on_o, !v);
		@(posedge clk_i);
		#2 chk(term_on_o, 1'b1);
		#5 chk(term_on_o, v);
	endtask

	// the dram end flags cke hold, write-to-read and exit-to-read slips the controller lets through
	always @(negedge clk_i) begin
		if (reset_n_i) chk(violation_o, 1'b0);
	end

	// ==========
	// main sequence
	initial begin
		int i;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(negedge clk_i);
		chk(freq_change_ok_o, 1'b0);
		send(CMD_MRS, 14'h0000);
		send(CMD_ACT, 14'h0010);
		send(CMD_PRE, 14'h0000);
		chk(gap, n_ras);
		send(CMD_ACT, 14'h0010);
		chk(gap, n_rp);
		repeat (6) @(posedge clk_i);
		send(CMD_RD, 14'h0010);
		send(CMD_PRE, 14'h0000);
		chk(gap, ADDITIVE_LATENCY + BURST_LENGTH / 2);
		send(CMD_ACT, 14'h0010);
		send(CMD_WR, 14'h0010);
		// strobe seen by the dram end one cycle after write latency runs out
		repeat (4) @(negedge clk_i);
		chk(strobe_busy_o, 1'b1);
		send(CMD_RD, 14'h0010);
		chk(gap, WRITE_LATENCY + BURST_LENGTH / 2 + 2);
		send(CMD_WRA, 14'h0010);
		send(CMD_ACT, 14'h0020);
		chk(gap, WRITE_LATENCY + BURST_LENGTH / 2 + WRITE_RECOVERY + n_rp);
		send(CMD_PDE, 14'h0000);
		repeat (2) @(negedge clk_i);
		chk(power_down_o, 1'b1);
		send(CMD_PDX, 14'h0000);
		chk(gap, 3);
		send(CMD_RD, 14'h0020);
		chk(gap, 2);
		send(CMD_PRE, 14'h0000);
		send(CMD_MRS, 14'h1000);
		repeat (2) @(negedge clk_i);
		chk(slow_exit_o, 1'b1);
		chk(cmd_o, CMD_MRS);
		send(CMD_ACT, 14'h0030);
		repeat (6) @(posedge clk_i);
		send(CMD_PDE, 14'h0000);
		send(CMD_PDX, 14'h0000);
		send(CMD_RD, 14'h0030);
		chk(gap, (FASTEST_GRADE != 0) ? 7 - ADDITIVE_LATENCY : 8 - ADDITIVE_LATENCY);
		send(CMD_PRE, 14'h0000);
		send(CMD_PDE, 14'h0000);
		freq_change_req_i <= 1'b1;
		// exit offered but not valid: ready must stay low while the clock may move
		req_cmd_i         <= CMD_PDX;
		repeat (5) @(negedge clk_i);
		chk(freq_change_ok_o, 1'b1);
		chk(req_ready_o, 1'b0);
		@(posedge clk_i);
		freq_change_req_i <= 1'b0;
		send(CMD_PDX, 14'h0000);
		send(CMD_ACT, 14'h0040);
		chk(gap, (FASTEST_GRADE != 0) ? 3 : 2);
		odt_step(1'b1);
		odt_step(1'b0);
		for (i = 0; i < 1000 && data_suspect_o !== 1'b1; i++) @(negedge clk_i);
		chk(data_suspect_o, 1'b1);
		chk(cyc, 8 + T_REFI_PS / CLK_PERIOD_PS);
		send(CMD_PRE, 14'h0000);
		send(CMD_REF, 14'h0000);
		rewrite_done_i <= 1'b1;
		@(posedge clk_i);
		rewrite_done_i <= 1'b0;
		@(negedge clk_i);
		chk(data_suspect_o, 1'b0);
		results();
	end
endmodule
`default_nettype wire
